// >>> verilog/pwmpm_map.svh
// Register offsets, field positions and reset values of the pulse block
`ifndef PWMPM_MAP_SVH
`define PWMPM_MAP_SVH
`define PWMPM_A_FLAGS3 8'h00
`define PWMPM_A_FLAGS4 8'h01
`define PWMPM_A_EN3 8'h02
`define PWMPM_A_EN4 8'h03
`define PWMPM_A_PRI3 8'h04
`define PWMPM_A_PRI4 8'h05
`define PWMPM_A_T1H 8'h06
`define PWMPM_A_T1L 8'h07
`define PWMPM_A_T3H 8'h08
`define PWMPM_A_T3L 8'h09
`define PWMPM_A_TB_BASE 8'h10
`define PWMPM_A_TB_LAST 8'h1B
`define PWMPM_A_PORTH_DIR 8'h20
`define PWMPM_A_OSC 8'h21
`define PWMPM_A_FLAGS2 8'h22
`define PWMPM_A_EN2 8'h23
`define PWMPM_A_CH_BASE 8'h30
`define PWMPM_A_CH_LAST 8'h43
`define PWMPM_F3_MASK 8'h06
`define PWMPM_F2_MASK 8'h80
`define PWMPM_F2_OSCF 7
`define PWMPM_OSC_MON 0
`define PWMPM_OSC_TWOSPD 1
`define PWMPM_OSC_INT 2
`define PWMPM_OSC_STABLE 3
`define PWMPM_OSC_IDLE 4
`define PWMPM_CTL_EN 0
`define PWMPM_DIR_RST 8'hFF
`define PWMPM_CNT_RST 8'h00
`define PWMPM_PRD_RST 8'hFF
`endif

// >>> verilog/pwmpm_pkg.sv
// Types shared by the pulse block files
package pwmpm_pkg;
	typedef enum logic {pwmpm_src_primary, pwmpm_src_internal} pwmpm_src_t;
	typedef logic [7:0] pwmpm_byte_t;
endpackage

// >>> verilog/pwmpm_timebase.sv
// One 8-bit timebase with period register, frozen during sleep
`timescale 1ns/1ps
`include "pwmpm_map.svh"
module pwmpm_timebase (
	input wire logic clk,
	input wire logic rst,
	input wire logic freeze,
	input wire logic wr_cnt,
	input wire logic wr_prd,
	input wire pwmpm_pkg::pwmpm_byte_t wdata,
	output pwmpm_pkg::pwmpm_byte_t count,
	output pwmpm_pkg::pwmpm_byte_t period,
	output logic roll
);
	import pwmpm_pkg::*;
	pwmpm_byte_t cnt_reg;
	pwmpm_byte_t prd_reg;
	assign count = cnt_reg;
	assign period = prd_reg;
	// Only live edges count, so a stop neither loses nor adds a step
	assign roll = !freeze && !wr_cnt && (cnt_reg == prd_reg);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_reg <= `PWMPM_CNT_RST;
		end else if (freeze) begin
			cnt_reg <= cnt_reg;
		end else if (wr_cnt) begin
			cnt_reg <= wdata;
		end else if (roll) begin
			cnt_reg <= `PWMPM_CNT_RST;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prd_reg <= `PWMPM_PRD_RST;
		end else if (wr_prd && !freeze) begin
			prd_reg <= wdata;
		end
	end
endmodule

// >>> verilog/pwmpm_channel.sv
// One pulse-width channel comparing a duty value with its timebase
`timescale 1ns/1ps
`include "pwmpm_map.svh"
module pwmpm_channel (
	input wire logic clk,
	input wire logic rst,
	input wire logic freeze,
	input wire logic enable,
	input wire pwmpm_pkg::pwmpm_byte_t duty,
	input wire pwmpm_pkg::pwmpm_byte_t count,
	input wire logic roll,
	output logic pin_out,
	output logic pin_oe,
	output logic event_pulse
);
	import pwmpm_pkg::*;
	logic out_reg;
	assign pin_out = out_reg;
	assign pin_oe = enable;
	assign event_pulse = enable && roll && !freeze;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_reg <= 1'b0;
		end else if (freeze) begin
			out_reg <= out_reg;
		end else begin
			out_reg <= enable && (count < duty);
		end
	end
endmodule

// >>> verilog/pwmpm_top.sv
// Pulse-width channels with timebases, flags and power-mode behaviour
`timescale 1ns/1ps
`include "pwmpm_map.svh"
module pwmpm_top #(
	parameter bit MEM_32K = 1'b0,
	parameter bit PINS_64 = 1'b0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire pwmpm_pkg::pwmpm_byte_t wdata,
	input wire logic wr,
	input wire logic rd,
	output pwmpm_pkg::pwmpm_byte_t rdata,
	input wire logic sleep_active,
	input wire logic primary_idle,
	input wire logic primary_clk_ok,
	input wire logic internal_clk_stable,
	output logic use_internal_clk,
	output logic [9:0] pin_out,
	output logic [9:0] pin_oe,
	output pwmpm_pkg::pwmpm_byte_t port_h_direction,
	output logic irq
);
	import pwmpm_pkg::*;

	function automatic logic in_span(input logic [7:0] a,
		input logic [7:0] lo, input logic [7:0] hi);
		in_span = (a >= lo) && (a <= hi);
	endfunction

	logic freeze;
	logic wr_ok;
	pwmpm_byte_t flags2_reg, flags3_reg, flags4_reg;
	pwmpm_byte_t en2_reg, en3_reg, en4_reg;
	pwmpm_byte_t pri3_reg, pri4_reg;
	pwmpm_byte_t dir_h_reg;
	pwmpm_byte_t osc_reg;
	pwmpm_byte_t rdata_reg, rd_next;
	logic [15:0] t1_reg, t3_reg;
	pwmpm_src_t src_reg;
	pwmpm_byte_t tb_cnt [6];
	pwmpm_byte_t tb_prd [6];
	logic [5:0] tb_roll;
	pwmpm_byte_t ch_duty [10];
	pwmpm_byte_t ch_ctl [10];
	logic [9:0] ch_evt;
	logic [7:0] tb_off, ch_off;
	logic clk_fail;
	pwmpm_byte_t f4_impl;

	// CPU is stopped in sleep, so no write can land then
	assign freeze = sleep_active;
	assign wr_ok = wr && !freeze;
	assign tb_off = addr - `PWMPM_A_TB_BASE;
	assign ch_off = addr - `PWMPM_A_CH_BASE;
	assign f4_impl = MEM_32K ? 8'h3F : 8'hFF;
	assign clk_fail = osc_reg[`PWMPM_OSC_MON] && !primary_clk_ok;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_tb
			if (MEM_32K && gi >= 4) begin : g_none
				assign tb_cnt[gi] = 8'h00;
				assign tb_prd[gi] = 8'h00;
				assign tb_roll[gi] = 1'b0;
			end else begin : g_real
				pwmpm_timebase u_tb (
					.clk(clk),
					.rst(rst),
					.freeze(freeze),
					.wr_cnt(wr_ok && in_span(addr, `PWMPM_A_TB_BASE,
						`PWMPM_A_TB_LAST) && tb_off[3:1] == 3'(gi) &&
						!tb_off[0]),
					.wr_prd(wr_ok && in_span(addr, `PWMPM_A_TB_BASE,
						`PWMPM_A_TB_LAST) && tb_off[3:1] == 3'(gi) &&
						tb_off[0]),
					.wdata(wdata),
					.count(tb_cnt[gi]),
					.period(tb_prd[gi]),
					.roll(tb_roll[gi])
				);
			end
		end
		for (gi = 0; gi < 10; gi++) begin : g_ch
			if (MEM_32K && gi >= 8) begin : g_none
				assign ch_duty[gi] = 8'h00;
				assign ch_ctl[gi] = 8'h00;
				assign pin_out[gi] = 1'b0;
				assign pin_oe[gi] = 1'b0;
				assign ch_evt[gi] = 1'b0;
			end else begin : g_real
				pwmpm_byte_t duty_reg, ctl_reg;
				logic [2:0] sel;
				logic sel_hit;
				assign sel_hit = wr_ok && in_span(addr, `PWMPM_A_CH_BASE,
					`PWMPM_A_CH_LAST) && ch_off[4:1] == 4'(gi);
				assign sel = (ctl_reg[3:1] > 3'h5) ? 3'h0 : ctl_reg[3:1];
				assign ch_duty[gi] = duty_reg;
				assign ch_ctl[gi] = ctl_reg;
				always_ff @(posedge clk or posedge rst) begin
					if (rst) begin
						duty_reg <= 8'h00;
						ctl_reg <= 8'h00;
					end else if (sel_hit && !ch_off[0]) begin
						duty_reg <= wdata;
					end else if (sel_hit && ch_off[0]) begin
						ctl_reg <= {4'h0, wdata[3:0]};
					end
				end
				pwmpm_channel u_ch (
					.clk(clk),
					.rst(rst),
					.freeze(freeze),
					.enable(ctl_reg[`PWMPM_CTL_EN]),
					.duty(duty_reg),
					.count(tb_cnt[sel]),
					.roll(tb_roll[sel]),
					.pin_out(pin_out[gi]),
					.pin_oe(pin_oe[gi]),
					.event_pulse(ch_evt[gi])
				);
			end
		end
	endgenerate

	// Sticky flags: hardware set beats a same-cycle write-one clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags3_reg <= 8'h00;
		end else if (!freeze) begin
			flags3_reg <= (flags3_reg & ~((wr_ok && addr == `PWMPM_A_FLAGS3)
				? wdata : 8'h00) | {5'h00, ch_evt[1], ch_evt[0], 1'b0})
				& `PWMPM_F3_MASK;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags4_reg <= 8'h00;
		end else if (!freeze) begin
			flags4_reg <= (flags4_reg & ~((wr_ok && addr == `PWMPM_A_FLAGS4)
				? wdata : 8'h00) | ch_evt[9:2]) & f4_impl;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			flags2_reg <= 8'h00;
		end else begin
			flags2_reg <= (flags2_reg & ~((wr_ok && addr == `PWMPM_A_FLAGS2)
				? wdata : 8'h00) | {clk_fail, 7'h00}) & `PWMPM_F2_MASK;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			en2_reg <= 8'h00;
			en3_reg <= 8'h00;
			en4_reg <= 8'h00;
			pri3_reg <= 8'h00;
			pri4_reg <= 8'h00;
		end else if (wr_ok) begin
			if (addr == `PWMPM_A_EN2) begin
				en2_reg <= wdata & `PWMPM_F2_MASK;
			end else if (addr == `PWMPM_A_EN3) begin
				en3_reg <= wdata & `PWMPM_F3_MASK;
			end else if (addr == `PWMPM_A_EN4) begin
				en4_reg <= wdata & f4_impl;
			end else if (addr == `PWMPM_A_PRI3) begin
				pri3_reg <= wdata & `PWMPM_F3_MASK;
			end else if (addr == `PWMPM_A_PRI4) begin
				pri4_reg <= wdata & f4_impl;
			end
		end
	end

	// Port H direction: all inputs after reset; absent on the small package
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir_h_reg <= `PWMPM_DIR_RST;
		end else if (wr_ok && addr == `PWMPM_A_PORTH_DIR && !PINS_64) begin
			dir_h_reg <= wdata;
		end
	end
	assign port_h_direction = dir_h_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			osc_reg <= 8'h00;
		end else if (wr_ok && addr == `PWMPM_A_OSC) begin
			osc_reg <= {6'h00, wdata[`PWMPM_OSC_TWOSPD],
				wdata[`PWMPM_OSC_MON]};
		end
	end

	// Failover holds until reset; the primary clock is not trusted again
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_reg <= pwmpm_src_primary;
		end else begin
			case (src_reg)
				pwmpm_src_primary: begin
					if (clk_fail) begin
						src_reg <= pwmpm_src_internal;
					end
				end
				default: begin
					src_reg <= pwmpm_src_internal;
				end
			endcase
		end
	end
	assign use_internal_clk = (src_reg == pwmpm_src_internal);

	// Free-running 16-bit timebases; primary idle leaves them running
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			t1_reg <= 16'h0000;
		end else if (freeze) begin
			t1_reg <= t1_reg;
		end else if (wr_ok && addr == `PWMPM_A_T1H) begin
			t1_reg <= {wdata, t1_reg[7:0]};
		end else if (wr_ok && addr == `PWMPM_A_T1L) begin
			t1_reg <= {t1_reg[15:8], wdata};
		end else begin
			t1_reg <= t1_reg + 16'h0001;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			t3_reg <= 16'h0000;
		end else if (freeze) begin
			t3_reg <= t3_reg;
		end else if (wr_ok && addr == `PWMPM_A_T3H) begin
			t3_reg <= {wdata, t3_reg[7:0]};
		end else if (wr_ok && addr == `PWMPM_A_T3L) begin
			t3_reg <= {t3_reg[15:8], wdata};
		end else begin
			t3_reg <= t3_reg + 16'h0001;
		end
	end

	always_comb begin
		rd_next = 8'h00;
		if (addr == `PWMPM_A_FLAGS3) begin
			rd_next = flags3_reg;
		end else if (addr == `PWMPM_A_FLAGS4) begin
			rd_next = flags4_reg;
		end else if (addr == `PWMPM_A_EN3) begin
			rd_next = en3_reg;
		end else if (addr == `PWMPM_A_EN4) begin
			rd_next = en4_reg;
		end else if (addr == `PWMPM_A_PRI3) begin
			rd_next = pri3_reg;
		end else if (addr == `PWMPM_A_PRI4) begin
			rd_next = pri4_reg;
		end else if (addr == `PWMPM_A_T1H) begin
			rd_next = t1_reg[15:8];
		end else if (addr == `PWMPM_A_T1L) begin
			rd_next = t1_reg[7:0];
		end else if (addr == `PWMPM_A_T3H) begin
			rd_next = t3_reg[15:8];
		end else if (addr == `PWMPM_A_T3L) begin
			rd_next = t3_reg[7:0];
		end else if (in_span(addr, `PWMPM_A_TB_BASE, `PWMPM_A_TB_LAST)) begin
			rd_next = tb_off[0] ? tb_prd[tb_off[3:1]] : tb_cnt[tb_off[3:1]];
		end else if (addr == `PWMPM_A_PORTH_DIR) begin
			rd_next = PINS_64 ? 8'h00 : dir_h_reg;
		end else if (addr == `PWMPM_A_OSC) begin
			rd_next = {3'h0, primary_idle, internal_clk_stable,
				use_internal_clk, osc_reg[1:0]};
		end else if (addr == `PWMPM_A_FLAGS2) begin
			rd_next = flags2_reg;
		end else if (addr == `PWMPM_A_EN2) begin
			rd_next = en2_reg;
		end else if (in_span(addr, `PWMPM_A_CH_BASE, `PWMPM_A_CH_LAST)) begin
			rd_next = ch_off[0] ? ch_ctl[ch_off[4:1]] : ch_duty[ch_off[4:1]];
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else begin
			rdata_reg <= rd ? rd_next : 8'h00;
		end
	end
	assign rdata = rdata_reg;

	assign irq = |(flags2_reg & en2_reg) | |(flags3_reg & en3_reg) |
		|(flags4_reg & en4_reg);

	logic first_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			first_reg <= 1'b1;
		end else begin
			first_reg <= 1'b0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	AST_T1_HOLD: assert property (sleep_active |=> $stable(t1_reg))
		else $error("timer1 moved in sleep");
	AST_FLAGS_HOLD: assert property (
		sleep_active |=> $stable(flags4_reg) && $stable(flags3_reg))
		else $error("flags moved in sleep");
	AST_PIN_HOLD: assert property (
		sleep_active [*2] |-> $stable(pin_out))
		else $error("pin changed in sleep");
	AST_RESUME: assert property (
		$fell(sleep_active) && !wr |=> t3_reg == $past(t3_reg) + 16'h0001)
		else $error("timer3 did not resume from frozen value");
	AST_IDLE_RUN: assert property (
		primary_idle && !sleep_active && !wr && !first_reg
		|=> t1_reg == $past(t1_reg) + 16'h0001)
		else $error("timer1 stalled in primary idle");
	AST_FAILOVER: assert property (
		osc_reg[`PWMPM_OSC_MON] && !primary_clk_ok
		|=> use_internal_clk && flags2_reg[`PWMPM_F2_OSCF])
		else $error("no failover on clock fail");
	AST_STAY_INT: assert property (
		use_internal_clk |=> use_internal_clk)
		else $error("left internal clock");
	AST_RESET_IN: assert property (
		first_reg |-> pin_oe == 10'h000 &&
		port_h_direction == `PWMPM_DIR_RST)
		else $error("pins not inputs after reset");
	AST_F4_MAP: assert property (
		ch_evt[2] && !sleep_active |=> flags4_reg[0])
		else $error("channel 3 flag missing");
	AST_F3_MAP: assert property (
		ch_evt[0] && !sleep_active |=> flags3_reg[1] &&
		(flags3_reg & ~`PWMPM_F3_MASK) == 8'h00)
		else $error("channel 1/2 flag layout wrong");
	AST_SMALL_MEM: assert property (
		MEM_32K |-> flags4_reg[7:6] == 2'b00 && pin_oe[9:8] == 2'b00)
		else $error("absent channels active");
	AST_PORTH_ZERO: assert property (
		PINS_64 && rd && addr == `PWMPM_A_PORTH_DIR |=> rdata == 8'h00)
		else $error("port H direction read not zero");

	CVR_SLEEP_WAKE: cover property (sleep_active ##1 !sleep_active);
	CVR_FAILOVER: cover property ($rose(use_internal_clk));
	CVR_IRQ: cover property ($rose(irq));
endmodule

// >>> verification/pwmpm_load.sv
// Load model on the pulse pins, counting level changes while watched
`timescale 1ns/1ps
module pwmpm_load (
	input wire logic clk,
	input wire logic [9:0] pin_out,
	input wire logic [9:0] pin_oe,
	input wire logic watch,
	output logic [9:0] level,
	output int changes
);
	logic watch_q = 1'b0;
	logic [9:0] last = 10'h000;
	int n_chg = 0;
	// Released pins fall to the pull-down, never the last driven value
	assign level = pin_out & pin_oe;
	assign changes = n_chg;
	// Count only inside a watch window, after its first edge
	always @(posedge clk) begin
		watch_q <= watch;
		last <= level;
		if (watch && watch_q && level !== last) begin
			n_chg <= n_chg + 1;
		end
	end
endmodule

// >>> verification/pwmpm_top_tb.sv
// Self-checking bench for the pulse block and its power-mode behaviour
`timescale 1ns/1ps
`include "pwmpm_map.svh"
module pwmpm_top_tb;
	import pwmpm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00;
	pwmpm_byte_t wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep_active = 1'b0;
	logic primary_idle = 1'b0;
	logic primary_clk_ok = 1'b1;
	logic internal_clk_stable = 1'b0;
	pwmpm_byte_t rdata_a, rdata_b, ph_a, ph_b;
	logic uic_a, uic_b, irq_a, irq_b;
	logic [9:0] po_a, oe_a, po_b, oe_b, level;
	int changes;
	int n_mismatch = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [7:0] da, db;

	pwmpm_top i_pwmpm_top (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata_a), .sleep_active(sleep_active),
		.primary_idle(primary_idle), .primary_clk_ok(primary_clk_ok),
		.internal_clk_stable(internal_clk_stable), .use_internal_clk(uic_a),
		.pin_out(po_a), .pin_oe(oe_a), .port_h_direction(ph_a), .irq(irq_a));
	// Small part: fewer channels and timebases, no port H direction
	pwmpm_top #(.MEM_32K(1'b1), .PINS_64(1'b1)) i_pwmpm_top_small (
		.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata_b), .sleep_active(sleep_active),
		.primary_idle(primary_idle), .primary_clk_ok(primary_clk_ok),
		.internal_clk_stable(internal_clk_stable), .use_internal_clk(uic_b),
		.pin_out(po_b), .pin_oe(oe_b), .port_h_direction(ph_b), .irq(irq_b));
	pwmpm_load i_pwmpm_load (.clk(clk), .pin_out(po_a), .pin_oe(oe_a),
		.watch(sleep_active), .level(level), .changes(changes));

	always #10 clk = ~clk;

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Ceiling well above the fewer than 200 cycles the sequence needs
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			print_verdict();
		end
	end

	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		da = rdata_a;
		db = rdata_b;
	endtask

	// Count steps of timebase 1 over a fixed span, part of it maybe asleep
	task gap(input logic slp, output logic [7:0] delta);
		logic [7:0] first;
		rd_reg(8'h12);
		first = da;
		@(posedge clk);
		sleep_active <= slp;
		repeat (2) @(posedge clk);
		if (slp) begin
			wr_reg(8'h12, 8'h80);
		end else begin
			repeat (2) @(posedge clk);
		end
		@(posedge clk);
		sleep_active <= 1'b0;
		rd_reg(8'h12);
		delta = da - first;
	endtask

	task t_reset_values;
		rd_reg(`PWMPM_A_TB_BASE + 8'h01);
		check(da, `PWMPM_PRD_RST);
		rd_reg(`PWMPM_A_PORTH_DIR);
		check(da, `PWMPM_DIR_RST);
		check(db, 8'h00);
		check(ph_b, `PWMPM_DIR_RST);
		check({7'h00, oe_a === 10'h000}, 8'h01);
		rd_reg(`PWMPM_A_FLAGS3);
		check(da, 8'h00);
		check({6'h00, uic_a, irq_a}, 8'h00);
	endtask

	task t_channel_flags;
		int n;
		n = 0;
		wr_reg(8'h11, 8'h03);
		// Restart the count below the new period, else it runs to the wrap
		wr_reg(8'h10, 8'h00);
		wr_reg(8'h30, 8'h02);
		wr_reg(8'h31, 8'h01);
		wr_reg(8'h35, 8'h01);
		repeat (8) @(posedge clk);
		rd_reg(`PWMPM_A_FLAGS3);
		check(da, 8'h02);
		rd_reg(`PWMPM_A_FLAGS4);
		check(da, 8'h01);
		check({7'h00, oe_a[0]}, 8'h01);
		// Duty 2 of a 4-step period: half the samples high
		repeat (8) begin
			@(posedge clk);
			#1;
			n += po_a[0];
		end
		check(8'(n), 8'h04);
		wr_reg(`PWMPM_A_EN3, 8'h02);
		#1;
		check({7'h00, irq_a}, 8'h01);
		wr_reg(`PWMPM_A_PRI3, 8'hFF);
		rd_reg(`PWMPM_A_PRI3);
		check(da, 8'h06);
		wr_reg(`PWMPM_A_PRI4, 8'hA5);
		rd_reg(`PWMPM_A_PRI4);
		check(da, 8'hA5);
		wr_reg(8'h31, 8'h00);
		wr_reg(8'h35, 8'h00);
		wr_reg(`PWMPM_A_FLAGS3, 8'h02);
		wr_reg(`PWMPM_A_FLAGS4, 8'h01);
		rd_reg(`PWMPM_A_FLAGS4);
		check(da, 8'h00);
		check({6'h00, oe_a[0], irq_a}, 8'h00);
	endtask

	task t_sleep;
		logic [7:0] delta;
		int c0;
		wr_reg(8'h31, 8'h01);
		c0 = changes;
		// Eight edges between reads, five of them asleep, write dropped
		gap(1'b1, delta);
		check(delta, 8'h03);
		check(8'(changes - c0), 8'h00);
		wr_reg(8'h31, 8'h00);
		wr_reg(`PWMPM_A_FLAGS3, 8'h02);
	endtask

	task t_idle;
		logic [7:0] delta;
		primary_idle <= 1'b1;
		gap(1'b0, delta);
		check(delta, 8'h08);
	endtask

	task t_failover;
		logic [7:0] delta;
		primary_clk_ok <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check({7'h00, uic_a}, 8'h00);
		primary_clk_ok <= 1'b1;
		wr_reg(`PWMPM_A_OSC, 8'h01);
		internal_clk_stable <= 1'b1;
		primary_clk_ok <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		check({7'h00, uic_a}, 8'h01);
		primary_clk_ok <= 1'b1;
		wr_reg(`PWMPM_A_EN2, 8'h80);
		#1;
		check({7'h00, irq_a}, 8'h01);
		rd_reg(`PWMPM_A_OSC);
		check(da, 8'h1D);
		wr_reg(`PWMPM_A_FLAGS2, 8'h80);
		rd_reg(`PWMPM_A_FLAGS2);
		check(da, 8'h00);
		check({6'h00, uic_a, irq_a}, 8'h02);
		gap(1'b0, delta);
		check(delta, 8'h08);
	endtask

	task t_small;
		wr_reg(`PWMPM_A_TB_LAST, 8'h33);
		rd_reg(`PWMPM_A_TB_LAST);
		check(da, 8'h33);
		check(db, 8'h00);
		wr_reg(8'h40, 8'h44);
		rd_reg(8'h40);
		check(da, 8'h44);
		check(db, 8'h00);
		wr_reg(`PWMPM_A_PORTH_DIR, 8'h0F);
		rd_reg(`PWMPM_A_PORTH_DIR);
		check(da, 8'h0F);
		check(db, 8'h00);
		check(ph_b, 8'hFF);
		// Low byte first, so no carry reaches the high byte before the read
		wr_reg(`PWMPM_A_T1L, 8'h00);
		wr_reg(`PWMPM_A_T1H, 8'h5A);
		rd_reg(`PWMPM_A_T1H);
		check(da, 8'h5A);
		wr_reg(8'hFF, 8'h12);
		rd_reg(8'hFF);
		check(da, 8'h00);
	endtask

	task t_rereset;
		@(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		#1;
		check({7'h00, oe_a === 10'h000}, 8'h01);
		check(ph_a, `PWMPM_DIR_RST);
		check({7'h00, uic_a}, 8'h00);
		rd_reg(`PWMPM_A_T1H);
		check(da, `PWMPM_CNT_RST);
		rd_reg(`PWMPM_A_PORTH_DIR);
		check(da, `PWMPM_DIR_RST);
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
		t_channel_flags();
		t_sleep();
		t_idle();
		t_failover();
		t_small();
		t_rereset();
		print_verdict();
	end
endmodule
